// >>> verilog/ssf_pkg.sv
// package: register map, field positions and sizes of the sample buffer
package ssf_pkg;
  localparam logic [7:0] OFS_WATERMARK_THRESHOLD = 8'h13;
  localparam logic [7:0] OFS_BUFFER_CONTROL = 8'h14;
  localparam logic [7:0] OFS_ENTRY_COUNT_LOW = 8'h15;
  localparam logic [7:0] OFS_BUFFER_STATUS = 8'h16;
  localparam logic [7:0] RST_WATERMARK_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_BUFFER_CONTROL = 8'h00;
  localparam int CTL_READ_MODE_BIT = 7;
  localparam int CTL_SIZE_LSB = 2;
  localparam int CTL_MODE_LSB = 0;
  localparam int STS_FULL_BIT = 7;
  localparam int STS_WATERMARK_BIT = 6;
  localparam int STS_OVERRUN_BIT = 5;
  localparam int STS_NOT_EMPTY_BIT = 4;
  localparam int STS_COUNT_HI_LSB = 0;
  localparam int COUNT_WIDTH = 10;
  localparam int WORD_WIDTH = 16;
  localparam int BUFFER_DEPTH = 32;
endpackage

// >>> verilog/ssf_fifo.sv
// module: word fifo with valid/ready on both sides and a fill count
`timescale 1ns/1ns
module ssf_fifo
  import ssf_pkg::*;
#(
  parameter int WIDTH = WORD_WIDTH,
  parameter int DEPTH = BUFFER_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clk_en, // state frozen while low
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // offered word
  output logic out_valid, // word available
  input wire logic out_ready, // consumer takes word
  output logic [WIDTH-1:0] out_data, // head word
  output logic [$clog2(DEPTH):0] fill // words held
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] next_fill;
  logic push, pop;

  always_comb begin
    in_ready = (fill != (AW+1)'(DEPTH));
    out_valid = (fill != '0);
    out_data = mem[rd_ptr];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_fill = fill + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill <= '0;
    end else if (clk_en) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      fill <= next_fill;
    end
  end

  always_ff @(posedge clk) begin
    if (clk_en && push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

// >>> verilog/ssf_regs.sv
// module: sample buffer with control and status registers
// How it works
// [RULE_01] 8-bit watermark threshold register, resets zero
// [RULE_02] direction bit zero: buffer accepts samples
// [RULE_03] direction bit one: host drains via data
// [RULE_04] command sets direction bit by itself
// [RULE_05] host clears direction bit to resume filling
// [RULE_06] size 3:2, mode 1:0, 6:4 reserved
// [RULE_07] count register: low eight word count bits
// [RULE_08] status bit 7: buffer full
// [RULE_09] status 1:0: count top two bits
// [RULE_10] status bit 6: watermark reached
// [RULE_11] status bit 5: overflow, samples discarded
// [RULE_12] status bit 4: buffer not empty
// [RULE_13] watermark when count >= nonzero threshold
`timescale 1ns/1ns
module ssf_regs
  import ssf_pkg::*;
#(
  parameter int DEPTH = BUFFER_DEPTH
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clk_en, // state frozen while low
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  input wire logic [7:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // write data
  output logic [7:0] reg_rdata, // read data, one cycle later
  input wire logic drain_cmd, // command: enter read mode
  input wire logic sample_valid, // sample word from sensors
  input wire logic [WORD_WIDTH-1:0] sample_data, // sample word
  input wire logic data_pop, // host reads one data word
  output logic [WORD_WIDTH-1:0] data_word, // head word for host
  output logic data_avail, // a data word can be read
  output logic [7:0] size_sel, // size and mode fields to sample path
  output logic read_mode // buffer in drain mode
);
  localparam int CW = $clog2(DEPTH) + 1;

  // ***************************************************************
  // registers
  // ***************************************************************
  logic [7:0] wm_thresh, next_wm_thresh;
  logic [7:0] ctrl, next_ctrl;
  logic overrun, next_overrun;
  logic [7:0] next_rdata;
  logic [7:0] status_val;
  logic [COUNT_WIDTH-1:0] count10;
  logic wm_hit, full;

  // ***************************************************************
  // buffer
  // ***************************************************************
  logic f_in_ready, f_out_valid, f_push_valid, f_pop;
  logic [WORD_WIDTH-1:0] f_out_data;
  logic [CW-1:0] f_fill;

  assign f_push_valid = sample_valid && !ctrl[CTL_READ_MODE_BIT]; // [RULE_02]
  assign f_pop = data_pop && ctrl[CTL_READ_MODE_BIT]; // [RULE_03]

  ssf_fifo #(.WIDTH(WORD_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .in_valid(f_push_valid),
    .in_ready(f_in_ready),
    .in_data(sample_data),
    .out_valid(f_out_valid),
    .out_ready(f_pop),
    .out_data(f_out_data),
    .fill(f_fill)
  );

  // ***************************************************************
  // status
  // ***************************************************************
  always_comb begin
    count10 = COUNT_WIDTH'(f_fill); // [RULE_07]
    full = !f_in_ready; // [RULE_08]
    wm_hit = (wm_thresh != 8'h00) &&
             (count10 >= {2'h0, wm_thresh}); // [RULE_13]
    status_val = 8'h00;
    status_val[STS_FULL_BIT] = full; // [RULE_08]
    status_val[STS_WATERMARK_BIT] = wm_hit; // [RULE_10]
    status_val[STS_OVERRUN_BIT] = overrun; // [RULE_11]
    status_val[STS_NOT_EMPTY_BIT] = f_out_valid; // [RULE_12]
    status_val[STS_COUNT_HI_LSB +: 2] = count10[9:8]; // [RULE_09]
  end

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    next_wm_thresh = wm_thresh;
    next_ctrl = ctrl;
    next_overrun = overrun;
    next_rdata = reg_rdata;
    if (reg_wr && reg_addr == OFS_WATERMARK_THRESHOLD) begin
      next_wm_thresh = reg_wdata; // [RULE_01]
    end
    if (reg_wr && reg_addr == OFS_BUFFER_CONTROL) begin
      next_ctrl = reg_wdata & 8'h8F; // [RULE_06] [RULE_05]
    end
    if (drain_cmd) begin
      next_ctrl[CTL_READ_MODE_BIT] = 1'b1; // [RULE_04]
    end
    if (sample_valid && !ctrl[CTL_READ_MODE_BIT] && !f_in_ready) begin
      next_overrun = 1'b1; // [RULE_11]
    end else if (f_pop) begin
      next_overrun = 1'b0;
    end
    if (reg_rd) begin
      case (reg_addr)
        OFS_WATERMARK_THRESHOLD: next_rdata = wm_thresh;
        OFS_BUFFER_CONTROL: next_rdata = ctrl;
        OFS_ENTRY_COUNT_LOW: next_rdata = count10[7:0]; // [RULE_07]
        OFS_BUFFER_STATUS: next_rdata = status_val;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wm_thresh <= RST_WATERMARK_THRESHOLD;
      ctrl <= RST_BUFFER_CONTROL;
      overrun <= 1'b0;
      reg_rdata <= 8'h00;
      data_word <= '0;
      data_avail <= 1'b0;
      size_sel <= 8'h00;
      read_mode <= 1'b0;
    end else if (clk_en) begin
      wm_thresh <= next_wm_thresh;
      ctrl <= next_ctrl;
      overrun <= next_overrun;
      reg_rdata <= next_rdata;
      data_word <= f_out_valid ? f_out_data : '0;
      data_avail <= f_out_valid && next_ctrl[CTL_READ_MODE_BIT];
      size_sel <= {4'h0, next_ctrl[CTL_SIZE_LSB +: 2],
                   next_ctrl[CTL_MODE_LSB +: 2]};
      read_mode <= next_ctrl[CTL_READ_MODE_BIT];
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  property p_thresh_write;
    @(posedge clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == OFS_WATERMARK_THRESHOLD
      |=> wm_thresh == $past(reg_wdata);
  endproperty
  a_thresh_write: assert property (p_thresh_write) // [RULE_01]
    else $error("threshold not written");

  property p_no_fill_in_drain;
    @(posedge clk) disable iff (sys_rst)
      clk_en && ctrl[7] && !f_pop |=> f_fill <= $past(f_fill);
  endproperty
  a_no_fill_in_drain: assert property (p_no_fill_in_drain) // [RULE_02]
    else $error("buffer filled in drain mode");

  property p_fill_accept;
    @(posedge clk) disable iff (sys_rst)
      clk_en && !ctrl[7] && sample_valid && f_in_ready
      |=> f_fill == $past(f_fill) + 1'b1;
  endproperty
  a_fill_accept: assert property (p_fill_accept) // [RULE_02]
    else $error("sample not accepted in fill mode");

  property p_drain_pop;
    @(posedge clk) disable iff (sys_rst)
      clk_en && ctrl[7] && data_pop && f_out_valid
      |=> f_fill == $past(f_fill) - 1'b1;
  endproperty
  a_drain_pop: assert property (p_drain_pop) // [RULE_03]
    else $error("drain pop lost");

  property p_cmd_sets;
    @(posedge clk) disable iff (sys_rst)
      clk_en && drain_cmd |=> ctrl[7] && read_mode;
  endproperty
  a_cmd_sets: assert property (p_cmd_sets) // [RULE_04]
    else $error("command did not set read mode");

  property p_reserved;
    @(posedge clk) disable iff (sys_rst) ctrl[6:4] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) // [RULE_06]
    else $error("reserved control bits set");

  property p_count_read;
    @(posedge clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == OFS_ENTRY_COUNT_LOW
      |=> reg_rdata == $past(count10[7:0]);
  endproperty
  a_count_read: assert property (p_count_read) // [RULE_07]
    else $error("count read wrong");

  property p_status_read;
    @(posedge clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == OFS_BUFFER_STATUS
      |=> reg_rdata[7] == $past(f_fill == DEPTH) &&
          reg_rdata[4] == $past(f_fill != 0) &&
          reg_rdata[1:0] == $past(count10[9:8]);
  endproperty
  a_status_read: assert property (p_status_read) // [RULE_08][RULE_09][RULE_12]
    else $error("status read wrong");

  property p_wm;
    @(posedge clk) disable iff (sys_rst)
      wm_hit == (wm_thresh != 0 && f_fill >= wm_thresh);
  endproperty
  a_wm: assert property (p_wm) // [RULE_10] [RULE_13]
    else $error("watermark flag wrong");

  property p_overrun;
    @(posedge clk) disable iff (sys_rst)
      clk_en && sample_valid && !ctrl[7] && full |=> overrun;
  endproperty
  a_overrun: assert property (p_overrun) // [RULE_11]
    else $error("overrun not flagged");

  property p_field_write;
    @(posedge clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == OFS_BUFFER_CONTROL
      |=> ctrl[3:0] == $past(reg_wdata[3:0]) &&
          size_sel[3:0] == $past(reg_wdata[3:0]);
  endproperty
  a_field_write: assert property (p_field_write) // [RULE_06]
    else $error("control fields not written");

  property p_resume;
    @(posedge clk) disable iff (sys_rst)
      clk_en && reg_wr && reg_addr == OFS_BUFFER_CONTROL &&
      !reg_wdata[CTL_READ_MODE_BIT] && !drain_cmd |=> !read_mode;
  endproperty
  a_resume: assert property (p_resume) // [RULE_05]
    else $error("fill mode not resumed");

  property p_drain_wins;
    @(posedge clk) disable iff (sys_rst)
      clk_en && drain_cmd && reg_wr && reg_addr == OFS_BUFFER_CONTROL
      |=> ctrl[CTL_READ_MODE_BIT];
  endproperty
  a_drain_wins: assert property (p_drain_wins) // [RULE_04]
    else $error("command lost to control write");

  property p_avail;
    @(posedge clk) disable iff (sys_rst)
      data_avail |-> read_mode;
  endproperty
  a_avail: assert property (p_avail) // [RULE_03]
    else $error("data offered outside drain mode");

  property p_discard;
    @(posedge clk) disable iff (sys_rst)
      clk_en && sample_valid && !ctrl[CTL_READ_MODE_BIT] && full
      |=> f_fill == $past(f_fill);
  endproperty
  a_discard: assert property (p_discard) // [RULE_11]
    else $error("sample stored while full");

  property p_drain_quiet;
    @(posedge clk) disable iff (sys_rst)
      ctrl[CTL_READ_MODE_BIT] && !overrun |=> !overrun;
  endproperty
  a_drain_quiet: assert property (p_drain_quiet) // [RULE_11]
    else $error("overrun raised in drain mode");

  property p_overrun_hold;
    @(posedge clk) disable iff (sys_rst)
      overrun && !f_pop |=> overrun;
  endproperty
  a_overrun_hold: assert property (p_overrun_hold) // [RULE_11]
    else $error("overrun flag lost");

  property p_status_flags;
    @(posedge clk) disable iff (sys_rst)
      clk_en && reg_rd && reg_addr == OFS_BUFFER_STATUS
      |=> reg_rdata[6] == $past(wm_hit) &&
          reg_rdata[5] == $past(overrun) &&
          reg_rdata[3:2] == 2'h0;
  endproperty
  a_status_flags: assert property (p_status_flags) // [RULE_10][RULE_11]
    else $error("status flags read wrong");

  property p_freeze;
    @(posedge clk) disable iff (sys_rst)
      !clk_en |=> wm_thresh == $past(wm_thresh) && ctrl == $past(ctrl) &&
                  f_fill == $past(f_fill) && overrun == $past(overrun);
  endproperty
  a_freeze: assert property (p_freeze) // [RULE_01]
    else $error("state moved while clock enable low");

  c_full: cover property (@(posedge clk) full);
  c_wm: cover property (@(posedge clk) wm_hit);
  c_overrun: cover property (@(posedge clk) overrun);
  c_drain: cover property (@(posedge clk) f_pop ##1 !ctrl[7]);
  c_resume: cover property (@(posedge clk) read_mode ##1 !read_mode);
endmodule

// >>> testbench/ssf_sample_src.sv
// partner model: sensor sample source that offers words to the buffer
`timescale 1ns/1ns
module ssf_sample_src
  import ssf_pkg::*;
(
  input wire logic clk, // system clock
  output logic sample_valid, // word offered
  output logic [WORD_WIDTH-1:0] sample_data // offered word
);
  initial begin
    sample_valid = 1'b0;
    sample_data = 16'h0000;
  end
  // offer n words, back to back or with idle gaps
  task automatic send(input int n);
    int gap;
    repeat (n) begin
      gap = $urandom_range(2);
      if (gap > 0) begin
        sample_valid <= 1'b0;
        sample_data <= ~sample_data;
        repeat (gap) @(posedge clk);
      end
      sample_valid <= 1'b1;
      sample_data <= 16'($urandom);
      @(posedge clk);
    end
    sample_valid <= 1'b0;
    sample_data <= ~sample_data;
  endtask
endmodule

// >>> testbench/testbench.sv
// testbench: self-checking bench for the sample buffer registers
`timescale 1ns/1ns
module testbench;
  import ssf_pkg::*;
  logic clk, sys_rst, clk_en, reg_wr, reg_rd, drain_cmd, data_pop;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, size_sel, r;
  logic sample_valid, data_avail, read_mode;
  logic [WORD_WIDTH-1:0] sample_data, data_word;
  logic [WORD_WIDTH-1:0] q[$];
  logic [7:0] m_thr, m_ctl;
  logic m_ovr;
  int num_errors = 0;
  int samples_checked = 0;
  ssf_regs u_dut(.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .drain_cmd(drain_cmd),
    .sample_valid(sample_valid), .sample_data(sample_data),
    .data_pop(data_pop), .data_word(data_word), .data_avail(data_avail),
    .size_sel(size_sel), .read_mode(read_mode));
  ssf_sample_src u_src(.clk(clk), .sample_valid(sample_valid),
    .sample_data(sample_data));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****************************************
  // behavioural model of buffer and registers
  // ****************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      q = {};
      m_thr = 8'h00;
      m_ctl = 8'h00;
      m_ovr = 1'b0;
    end else if (clk_en) begin
      if (data_pop && m_ctl[7] && q.size() > 0) begin
        void'(q.pop_front());
        m_ovr = 1'b0;
      end
      if (sample_valid && !m_ctl[7]) begin
        if (q.size() < BUFFER_DEPTH) q.push_back(sample_data);
        else m_ovr = 1'b1;
      end
      if (reg_wr && reg_addr == OFS_WATERMARK_THRESHOLD) m_thr = reg_wdata;
      if (reg_wr && reg_addr == OFS_BUFFER_CONTROL) m_ctl = reg_wdata & 8'h8F;
      if (drain_cmd) m_ctl[7] = 1'b1;
    end
  end
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    int n;
    n = q.size();
    case (a)
      OFS_WATERMARK_THRESHOLD: return m_thr;
      OFS_BUFFER_CONTROL: return m_ctl;
      OFS_ENTRY_COUNT_LOW: return n[7:0];
      OFS_BUFFER_STATUS: return {n == BUFFER_DEPTH, m_thr != 0 && n >= m_thr,
        m_ovr, n > 0, 2'b00, n[9:8]};
      default: return 8'h00;
    endcase
  endfunction
  // ****************************************
  // bus tasks and comparison
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [7:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    check($sformatf("reg %h", a), {8'h00, reg_rdata}, {8'h00, exp_reg(a)});
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1000000;
    num_errors++;
    complete_run;
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hd0a3bd94));
    {sys_rst, clk_en} = 2'b11;
    {reg_wr, reg_rd, drain_cmd, data_pop} = 4'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    for (int a = 8'h13; a <= 8'h17; a++) chk(8'(a));
    r = 8'($urandom) & 8'h7F;
    wr(OFS_BUFFER_CONTROL, r);
    @(posedge clk);
    check("size_sel", {8'h00, size_sel}, {12'h000, r[3:0]});
    chk(OFS_BUFFER_CONTROL);
    wr(OFS_WATERMARK_THRESHOLD, 8'h04);
    clk_en <= 1'b0;
    @(posedge clk);
    wr(OFS_WATERMARK_THRESHOLD, 8'h20);
    clk_en <= 1'b1;
    @(posedge clk);
    chk(OFS_WATERMARK_THRESHOLD);
    u_src.send(3);
    chk(OFS_BUFFER_STATUS);
    u_src.send(1);
    chk(OFS_BUFFER_STATUS);
    wr(OFS_ENTRY_COUNT_LOW, 8'hFF);
    wr(OFS_BUFFER_STATUS, 8'hFF);
    chk(OFS_ENTRY_COUNT_LOW);
    u_src.send(30);
    repeat (2) @(posedge clk);
    chk(OFS_ENTRY_COUNT_LOW);
    chk(OFS_BUFFER_STATUS);
    drain_cmd <= 1'b1;
    @(posedge clk);
    drain_cmd <= 1'b0;
    repeat (3) @(posedge clk);
    check("read_mode", read_mode, 1'b1);
    u_src.send(2);
    chk(OFS_ENTRY_COUNT_LOW);
    for (int i = 0; i < 40 && q.size() > 0; i++) begin
      check("data_avail", data_avail, 1'b1);
      check("data_word", data_word, q[0]);
      data_pop <= 1'b1;
      @(posedge clk);
      data_pop <= 1'b0;
      repeat (2) @(posedge clk);
    end
    check("drained", 16'(q.size()), 16'h0000);
    check("data_avail", data_avail, 1'b0);
    chk(OFS_BUFFER_STATUS);
    wr(OFS_BUFFER_CONTROL, 8'h00);
    repeat (2) @(posedge clk);
    check("read_mode", read_mode, 1'b0);
    u_src.send(2);
    repeat (2) @(posedge clk);
    chk(OFS_ENTRY_COUNT_LOW);
    data_pop <= 1'b1;
    @(posedge clk);
    data_pop <= 1'b0;
    @(posedge clk);
    chk(OFS_ENTRY_COUNT_LOW);
    drain_cmd <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= OFS_BUFFER_CONTROL;
    reg_wdata <= 8'h00;
    @(posedge clk);
    {drain_cmd, reg_wr} <= 2'b00;
    @(posedge clk);
    chk(OFS_BUFFER_CONTROL);
    data_pop <= 1'b1;
    @(posedge clk);
    data_pop <= 1'b0;
    wr(OFS_WATERMARK_THRESHOLD, 8'h00);
    wr(OFS_BUFFER_CONTROL, 8'h00);
    chk(OFS_BUFFER_STATUS);
    complete_run;
  end
endmodule
